// ### src/redriver_pkg.sv
// Purpose: Shared constants and types of the redriver control logic.
// Assumes: Four-level straps arrive already coded as two bits.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package redriver_pkg;
   localparam logic [1:0] LVL_L0 = 2'h0;
   localparam logic [1:0] LVL_L1 = 2'h1;
   localparam logic [1:0] LVL_L2 = 2'h2;
   localparam logic [1:0] LVL_L3 = 2'h3;
   localparam logic [1:0] MODE_PIN    = LVL_L0;
   localparam logic [1:0] MODE_MASTER = LVL_L1;
   localparam logic [1:0] MODE_SLAVE  = LVL_L2;
   localparam logic [1:0] DETECT_OFF  = LVL_L0;

   typedef enum logic [1:0] {
      DET_OFF   = 2'b00,
      DET_POLL  = 2'b01,
      DET_FOUND = 2'b10,
      DET_PWRDN = 2'b11
   } det_state_type;

   localparam int CLK_PERIOD_PS  = 25000;
   localparam int POLL_PERIOD_US = 150;
   localparam int POLL_CYCLES    = POLL_PERIOD_US * 1000000 / CLK_PERIOD_PS;
   localparam int STRAP_SETTLE   = 3;

   localparam logic [7:0] ADR_CTRL    = 8'h00;
   localparam logic [7:0] ADR_EQ_A    = 8'h04;
   localparam logic [7:0] ADR_EQ_B    = 8'h08;
   localparam logic [7:0] ADR_STATUS  = 8'h0C;
   localparam logic [7:0] ADR_APPLIED = 8'h10;

   localparam int CTRL_RESTART_A = 0;
   localparam int CTRL_RESTART_B = 1;
   localparam int EQ_IDX_LSB     = 0;
   localparam int EQ_GAIN_LSB    = 4;
   localparam logic [3:0] EQ_RESET   = 4'h0;
   localparam logic [1:0] GAIN_RESET = LVL_L3;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : redriver_pkg

// ### src/detect_group_if.sv
// Purpose: Signals between the top control and one detect group.
// Assumes: Both ends run on the same clock.
// Notes:   One instance per four-channel group.
`timescale 1ns/1ps
interface detect_group_if;
   logic                       restart;
   logic                       powerDown;
   logic                       detectEnable;
   logic                       farEndSeen;
   logic                       probe;
   logic                       termOn;
   logic                       pathReset;
   redriver_pkg::det_state_type state;

   modport ctrl (
      output restart,
      output powerDown,
      output detectEnable,
      output farEndSeen,
      input  probe,
      input  termOn,
      input  pathReset,
      input  state
   );

   modport group (
      input  restart,
      input  powerDown,
      input  detectEnable,
      input  farEndSeen,
      output probe,
      output termOn,
      output pathReset,
      output state
   );
endinterface : detect_group_if

// ### src/strap_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin levels.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module strap_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;

   if (WIDTH < 1) begin : g_bad_width
      $error("strap_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         dout     <= '0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule : strap_sync

// ### src/rx_detect_group.sv
// Purpose: Receiver-detect state machine for one four-channel group.
// Assumes: farEndSeen is already synchronised.
// Notes:   termOn high means 50 ohm, low means high impedance.
`timescale 1ns/1ps
module rx_detect_group #(
   parameter int POLL_CYCLES = redriver_pkg::POLL_CYCLES
) (
   input wire logic     clk,
   input wire logic     rst,
   detect_group_if.group grp
);
   localparam int CW = $clog2(POLL_CYCLES);

   redriver_pkg::det_state_type state_reg;
   redriver_pkg::det_state_type state_next;
   logic [CW-1:0]               count_reg;
   logic                        expire;

   if (POLL_CYCLES < 2) begin : g_bad_poll
      $error("rx_detect_group: POLL_CYCLES < 2");
   end

   assign expire = (count_reg == CW'(POLL_CYCLES - 1));

   always_comb begin
      state_next = state_reg;
      if (grp.powerDown) begin
         state_next = redriver_pkg::DET_PWRDN;
      end else if (!grp.detectEnable) begin
         state_next = redriver_pkg::DET_OFF;
      end else if (grp.restart) begin
         state_next = redriver_pkg::DET_POLL;
      end else begin
         unique case (state_reg)
            redriver_pkg::DET_OFF,
            redriver_pkg::DET_PWRDN: state_next = redriver_pkg::DET_POLL;
            redriver_pkg::DET_POLL: begin
               if (expire && grp.farEndSeen) begin
                  state_next = redriver_pkg::DET_FOUND;
               end
            end
            redriver_pkg::DET_FOUND: state_next = redriver_pkg::DET_FOUND;
         endcase
      end
   end

   // The poll timer runs only while polling and restarts on every entry.
   always_ff @(posedge clk) begin
      if (rst || state_next != redriver_pkg::DET_POLL ||
          state_reg != redriver_pkg::DET_POLL) begin
         count_reg <= '0;
      end else if (expire) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg     <= redriver_pkg::DET_PWRDN;
         grp.termOn    <= 1'b0;
         grp.pathReset <= 1'b1;
         grp.probe     <= 1'b0;
      end else begin
         state_reg     <= state_next;
         grp.termOn    <= (state_next == redriver_pkg::DET_OFF) ||
                          (state_next == redriver_pkg::DET_FOUND);
         grp.pathReset <= (state_next == redriver_pkg::DET_PWRDN);
         grp.probe     <= (state_reg == redriver_pkg::DET_POLL) &&
                          (state_next == redriver_pkg::DET_POLL) &&
                          (count_reg == CW'(POLL_CYCLES - 2));
      end
   end

   assign grp.state = state_reg;
endmodule : rx_detect_group

// ### src/redriver_rx_detect_control.sv
// Purpose: Strap decode, receiver-detect control and crosspoint select
//          of an eight-channel redriver, with a Wishbone register file.
// Assumes: All strap, power-down, select and far-end inputs are
//          asynchronous pins; one clock; synchronous active-high reset.
// Notes:   Group A is channels 0-3, group B is channels 4-7.
`timescale 1ns/1ps

// Function
// - Pin-mode EQ index is upper strap times four plus lower strap.
// - EQ straps apply only while the configuration-mode strap is L0.
// - Strap pair A drives channels 0-3, pair B channels 4-7.
// - Register-written EQ applies in bus slave and bus master modes.
// - In pin mode gain strap A sets group A, strap B group B.
// - Detection restarts at power-up, power-down release, register write.
// - A change on a crosspoint select restarts detection for its group.
// - Power-down A acts on channels 0-3, power-down B on 4-7.
// - Both power-downs low with detect strap L0 holds 50 ohm always.
// - Otherwise hold high impedance, poll every 150 us, 50 ohm once found.
// - Power-down A alone resets group A path, high impedance there.
// - Power-down B alone resets group B path, high impedance there.
// - Each select sets its group straight or crossed.
// - Straps sample once after reset; the mode strap is always live.
// - Both power-downs high enter standby, all terminations high impedance.
module redriver_rx_detect_control #(
   parameter int POLL_CYCLES = redriver_pkg::POLL_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [1:0]  eq_upper_strap_group_a,
   input  wire logic [1:0]  eq_lower_strap_group_a,
   input  wire logic [1:0]  eq_upper_strap_group_b,
   input  wire logic [1:0]  eq_lower_strap_group_b,
   input  wire logic [1:0]  flat_gain_strap_group_a,
   input  wire logic [1:0]  flat_gain_strap_group_b,
   input  wire logic [1:0]  configModeStrap,
   input  wire logic [1:0]  detect_mode_strap,
   input  wire logic        powerdown_group_a,
   input  wire logic        powerdown_group_b,
   input  wire logic        crosspoint_select_a,
   input  wire logic        crosspoint_select_b,
   input  wire logic        farEndTermA,
   input  wire logic        farEndTermB,
   output logic      [3:0]  eqIndexA,
   output logic      [3:0]  eqIndexB,
   output logic      [1:0]  flatGainA,
   output logic      [1:0]  flatGainB,
   output logic             crossA,
   output logic             crossB,
   output logic             termOnA,
   output logic             termOnB,
   output logic             pathResetA,
   output logic             pathResetB,
   output logic             probeA,
   output logic             probeB,
   output logic             standby
);
   localparam int SYNC_W = 22;
   localparam int SW     = $clog2(redriver_pkg::STRAP_SETTLE + 1);

   // Synchronised pin levels.
   logic [SYNC_W-1:0] pinsRaw;
   logic [SYNC_W-1:0] pinsSync;
   logic [1:0]        eqUpA;
   logic [1:0]        eqLoA;
   logic [1:0]        eqUpB;
   logic [1:0]        eqLoB;
   logic [1:0]        gainPinA;
   logic [1:0]        gainPinB;
   logic [1:0]        modeLive;
   logic [1:0]        detPin;
   logic              pdA;
   logic              pdB;
   logic              selA;
   logic              selB;
   logic              farA;
   logic              farB;

   // Straps captured once after reset release.
   logic [SW-1:0]     settle_reg;
   logic              captured_reg;
   logic [3:0]        strapEqA_reg;
   logic [3:0]        strapEqB_reg;
   logic [1:0]        strapGainA_reg;
   logic [1:0]        strapGainB_reg;
   logic [1:0]        detMode_reg;

   // Edge history for restart triggers.
   logic              pdA_reg;
   logic              pdB_reg;
   logic              selA_reg;
   logic              selB_reg;
   logic              powerUp;
   logic              restartA;
   logic              restartB;

   // Register file.
   logic [3:0]        regEqA_reg;
   logic [3:0]        regEqB_reg;
   logic [1:0]        regGainA_reg;
   logic [1:0]        regGainB_reg;
   logic              swRestartA_reg;
   logic              swRestartB_reg;
   logic              request;
   logic              writeNow;
   logic [31:0]       readData;
   logic              pinMode;
   logic              detectEnable;

   detect_group_if groupA ();
   detect_group_if groupB ();

   assign pinsRaw = {eq_upper_strap_group_a, eq_lower_strap_group_a,
                     eq_upper_strap_group_b, eq_lower_strap_group_b,
                     flat_gain_strap_group_a, flat_gain_strap_group_b,
                     configModeStrap, detect_mode_strap,
                     powerdown_group_a, powerdown_group_b,
                     crosspoint_select_a, crosspoint_select_b,
                     farEndTermA, farEndTermB};

   strap_sync #(
      .WIDTH (SYNC_W)
   ) pinSync (
      .clk  (clk),
      .rst  (rst),
      .din  (pinsRaw),
      .dout (pinsSync)
   );

   assign {eqUpA, eqLoA, eqUpB, eqLoB, gainPinA, gainPinB,
           modeLive, detPin, pdA, pdB, selA, selB, farA, farB} = pinsSync;

   // The synchroniser needs two edges to show real pin levels, so the
   // capture waits a little longer than that after reset release.
   always_ff @(posedge clk) begin
      if (rst) begin
         settle_reg   <= '0;
         captured_reg <= 1'b0;
      end else if (!captured_reg) begin
         if (settle_reg == SW'(redriver_pkg::STRAP_SETTLE)) begin
            captured_reg <= 1'b1;
         end else begin
            settle_reg <= settle_reg + SW'(1);
         end
      end
   end

   assign powerUp = !captured_reg &&
                    (settle_reg == SW'(redriver_pkg::STRAP_SETTLE));

   always_ff @(posedge clk) begin
      if (rst) begin
         strapEqA_reg   <= redriver_pkg::EQ_RESET;
         strapEqB_reg   <= redriver_pkg::EQ_RESET;
         strapGainA_reg <= redriver_pkg::GAIN_RESET;
         strapGainB_reg <= redriver_pkg::GAIN_RESET;
         detMode_reg    <= redriver_pkg::LVL_L3;
      end else if (powerUp) begin
         strapEqA_reg   <= {eqUpA, eqLoA};
         strapEqB_reg   <= {eqUpB, eqLoB};
         strapGainA_reg <= gainPinA;
         strapGainB_reg <= gainPinB;
         detMode_reg    <= detPin;
      end
   end

   // The mode strap stays live, so the EQ source may switch at run time.
   assign pinMode = (modeLive == redriver_pkg::MODE_PIN);

   always_ff @(posedge clk) begin
      if (rst) begin
         eqIndexA  <= redriver_pkg::EQ_RESET;
         eqIndexB  <= redriver_pkg::EQ_RESET;
         flatGainA <= redriver_pkg::GAIN_RESET;
         flatGainB <= redriver_pkg::GAIN_RESET;
      end else if (pinMode) begin
         eqIndexA  <= strapEqA_reg;
         eqIndexB  <= strapEqB_reg;
         flatGainA <= strapGainA_reg;
         flatGainB <= strapGainB_reg;
      end else begin
         eqIndexA  <= regEqA_reg;
         eqIndexB  <= regEqB_reg;
         flatGainA <= regGainA_reg;
         flatGainB <= regGainB_reg;
      end
   end

   // Crosspoint select follows the synchronised pins directly.
   always_ff @(posedge clk) begin
      if (rst) begin
         crossA <= 1'b0;
         crossB <= 1'b0;
      end else begin
         crossA <= selA;
         crossB <= selB;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pdA_reg  <= 1'b0;
         pdB_reg  <= 1'b0;
         selA_reg <= 1'b0;
         selB_reg <= 1'b0;
      end else begin
         pdA_reg  <= pdA;
         pdB_reg  <= pdB;
         selA_reg <= selA;
         selB_reg <= selB;
      end
   end

   // A select toggle before capture is ignored: power-up restarts anyway.
   assign restartA = powerUp ||
                     (pdA_reg && !pdA && pinMode) ||
                     (captured_reg && selA != selA_reg) ||
                     swRestartA_reg;
   assign restartB = powerUp ||
                     (pdB_reg && !pdB && pinMode) ||
                     (captured_reg && selB != selB_reg) ||
                     swRestartB_reg;

   assign detectEnable = !(detMode_reg == redriver_pkg::DETECT_OFF &&
                           !pdA && !pdB);

   // Until the straps are captured both groups stay powered down.
   assign groupA.powerDown    = pdA || !captured_reg;
   assign groupB.powerDown    = pdB || !captured_reg;
   assign groupA.restart      = restartA;
   assign groupB.restart      = restartB;
   assign groupA.detectEnable = detectEnable;
   assign groupB.detectEnable = detectEnable;
   assign groupA.farEndSeen   = farA;
   assign groupB.farEndSeen   = farB;

   rx_detect_group #(
      .POLL_CYCLES (POLL_CYCLES)
   ) detectA (
      .clk (clk),
      .rst (rst),
      .grp (groupA)
   );

   rx_detect_group #(
      .POLL_CYCLES (POLL_CYCLES)
   ) detectB (
      .clk (clk),
      .rst (rst),
      .grp (groupB)
   );

   assign termOnA    = groupA.termOn;
   assign termOnB    = groupB.termOn;
   assign pathResetA = groupA.pathReset;
   assign pathResetB = groupB.pathReset;
   assign probeA     = groupA.probe;
   assign probeB     = groupB.probe;

   always_ff @(posedge clk) begin
      if (rst) begin
         standby <= 1'b0;
      end else begin
         standby <= pdA && pdB;
      end
   end

   // Wishbone slave: ack follows the request by one edge, and a write
   // lands on the same edge at which the master sees that ack.
   assign request  = cyc_i && stb_i;
   assign writeNow = request && we_i && ack_o && sel_i[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= request && !ack_o;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         regEqA_reg   <= redriver_pkg::EQ_RESET;
         regEqB_reg   <= redriver_pkg::EQ_RESET;
         regGainA_reg <= redriver_pkg::GAIN_RESET;
         regGainB_reg <= redriver_pkg::GAIN_RESET;
      end else if (writeNow && adr_i == redriver_pkg::ADR_EQ_A) begin
         regEqA_reg   <= dat_i[redriver_pkg::EQ_IDX_LSB +: 4];
         regGainA_reg <= dat_i[redriver_pkg::EQ_GAIN_LSB +: 2];
      end else if (writeNow && adr_i == redriver_pkg::ADR_EQ_B) begin
         regEqB_reg   <= dat_i[redriver_pkg::EQ_IDX_LSB +: 4];
         regGainB_reg <= dat_i[redriver_pkg::EQ_GAIN_LSB +: 2];
      end
   end

   // Restart bits are one-cycle pulses and always read back as zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         swRestartA_reg <= 1'b0;
         swRestartB_reg <= 1'b0;
      end else begin
         swRestartA_reg <= writeNow && adr_i == redriver_pkg::ADR_CTRL &&
                           dat_i[redriver_pkg::CTRL_RESTART_A];
         swRestartB_reg <= writeNow && adr_i == redriver_pkg::ADR_CTRL &&
                           dat_i[redriver_pkg::CTRL_RESTART_B];
      end
   end

   always_comb begin
      readData = redriver_pkg::DATA_ZERO;
      unique case (adr_i)
         redriver_pkg::ADR_EQ_A: begin
            readData[redriver_pkg::EQ_IDX_LSB +: 4]  = regEqA_reg;
            readData[redriver_pkg::EQ_GAIN_LSB +: 2] = regGainA_reg;
         end
         redriver_pkg::ADR_EQ_B: begin
            readData[redriver_pkg::EQ_IDX_LSB +: 4]  = regEqB_reg;
            readData[redriver_pkg::EQ_GAIN_LSB +: 2] = regGainB_reg;
         end
         redriver_pkg::ADR_STATUS: begin
            readData[12:0] = {crossB, crossA, standby, termOnB, termOnA,
                              groupB.state, groupA.state,
                              detMode_reg, modeLive};
         end
         redriver_pkg::ADR_APPLIED: begin
            readData[11:0] = {flatGainB, flatGainA, eqIndexB, eqIndexA};
         end
         default: readData = redriver_pkg::DATA_ZERO;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dat_o <= redriver_pkg::DATA_ZERO;
      end else if (request && !ack_o && !we_i) begin
         dat_o <= readData;
      end
   end
endmodule : redriver_rx_detect_control

// ### verif/far_end_model.sv
// Purpose: Far-end receiver termination seen by both detect groups.
// Assumes: presentA/B say whether a link partner is plugged in.
// Notes:   The level settles two cycles after the plug changes.
`timescale 1ns/1ps
module far_end_model (
   input  wire logic clk,
   input  wire logic presentA,
   input  wire logic presentB,
   output logic      farEndTermA,
   output logic      farEndTermB
);
   logic [1:0] dlyA;
   logic [1:0] dlyB;

   always_ff @(posedge clk) begin
      dlyA <= {dlyA[0], presentA};
      dlyB <= {dlyB[0], presentB};
   end

   assign farEndTermA = dlyA[1];
   assign farEndTermB = dlyB[1];
endmodule : far_end_model

// ### verif/redriver_checker.sv
// Purpose: Port-level checks of the redriver control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Pin windows allow two sync stages plus state and output edges.
`timescale 1ns/1ps
module redriver_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic [1:0]  detect_mode_strap,
   input wire logic        powerdown_group_a,
   input wire logic        powerdown_group_b,
   input wire logic        crosspoint_select_a,
   input wire logic        crossA,
   input wire logic        termOnA,
   input wire logic        termOnB,
   input wire logic        pathResetA,
   input wire logic        pathResetB,
   input wire logic        probeA,
   input wire logic        standby
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // The detect strap is captured once, so only a strap low since reset counts.
   logic seenDet;
   always_ff @(posedge clk) begin
      if (rst)
         seenDet <= 1'h0;
      else if (detect_mode_strap != 2'h0)
         seenDet <= 1'h1;
   end

   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_hole;
      s_req ##0 (!we_i && adr_i == 8'h14);
   endsequence
   sequence s_buf;
      (!seenDet && !powerdown_group_a && !powerdown_group_b) [*8];
   endsequence

   property p_ack;
      s_req |=> ack_o ##1 !ack_o;
   endproperty
   property p_hole;
      s_hole |=> dat_o == 32'h0000_0000;
   endproperty
   property p_cross_hi;
      crosspoint_select_a [*5] |-> crossA;
   endproperty
   property p_cross_lo;
      !crosspoint_select_a [*5] |-> !crossA;
   endproperty
   property p_buf;
      s_buf |-> termOnA && termOnB;
   endproperty
   property p_pd_a;
      powerdown_group_a [*6] |-> pathResetA && !termOnA;
   endproperty
   property p_pd_b;
      powerdown_group_b [*6] |-> pathResetB && !termOnB;
   endproperty
   property p_stby;
      (powerdown_group_a && powerdown_group_b) [*6]
         |-> standby && !termOnA && !termOnB;
   endproperty
   property p_probe;
      probeA |-> !termOnA ##1 !probeA;
   endproperty

   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_hole: assert property (p_hole) else $error("hole read not zero");
   a_cross_hi: assert property (p_cross_hi)
      else $error("crossed path not set");
   a_cross_lo: assert property (p_cross_lo)
      else $error("straight path not set");
   a_buf: assert property (p_buf) else $error("buffer term off");
   a_pd_a: assert property (p_pd_a) else $error("group A not down");
   a_pd_b: assert property (p_pd_b) else $error("group B not down");
   a_stby: assert property (p_stby) else $error("no standby");
   a_probe: assert property (p_probe) else $error("bad probe");
endmodule : redriver_checker

bind redriver_rx_detect_control redriver_checker i_chk (.*);

// ### verif/testbench.sv
// Purpose: Self-checking bench of the redriver control block.
// Assumes: Straps are set before reset is released.
// Notes:   Poll period is shortened; power-down pulses keep full length.
`timescale 1ns/1ps
module testbench;
   localparam int POLL    = 8;
   localparam int PD_HOLD = 8000;
   logic        clk, rst, cyc_i, stb_i, we_i, ack_o, standby, presA, presB;
   logic        powerdown_group_a, powerdown_group_b, crossA, crossB;
   logic        crosspoint_select_a, crosspoint_select_b, probeA, probeB;
   logic        farEndTermA, farEndTermB, termOnA, termOnB;
   logic        pathResetA, pathResetB;
   logic [1:0]  eq_upper_strap_group_a, eq_lower_strap_group_a;
   logic [1:0]  eq_upper_strap_group_b, eq_lower_strap_group_b;
   logic [1:0]  flat_gain_strap_group_a, flat_gain_strap_group_b;
   logic [1:0]  configModeStrap, detect_mode_strap, flatGainA, flatGainB;
   logic [3:0]  sel_i, eqIndexA, eqIndexB;
   logic [7:0]  adr_i;
   logic [31:0] dat_i, dat_o, q;
   int          mismatches, n_tests, cycles, n;

   redriver_rx_detect_control #(.POLL_CYCLES(POLL)) i_dut (.*);
   far_end_model i_far (.clk, .presentA(presA), .presentB(presB),
      .farEndTermA, .farEndTermB);

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do
         tick(1);
      while (ack_o !== 1'h1);
      q = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      tick(1);
   endtask : wb

   task automatic wait_term(input int g, input logic v);
      n = 0;
      while ((g ? termOnB : termOnA) !== v && n < 60) begin
         tick(1);
         n++;
      end
      check(g ? termOnB : termOnA, v);
   endtask : wait_term

   task automatic wait_probe();
      n = 0;
      do begin
         tick(1);
         n++;
      end while (probeA !== 1'h1 && n < 40);
   endtask : wait_probe

   task automatic t_straps();
      tick(8);
      check(eqIndexA, 4'hB);
      check(eqIndexB, 4'hD);
      check({flatGainB, flatGainA}, 4'hD);
      wb(1'h0, 8'h10, 32'h0000_0000);
      check(q, 32'h0000_0DDB);
      eq_upper_strap_group_a <= 2'h0;
      tick(6);
      check(eqIndexA, 4'hB);
      $display("test straps done");
   endtask : t_straps

   task automatic t_regs();
      logic [1:0] modes [2] = '{redriver_pkg::MODE_SLAVE,
                                redriver_pkg::MODE_MASTER};
      wb(1'h1, 8'h04, 32'h0000_0025);
      tick(4);
      check(eqIndexA, 4'hB);
      foreach (modes[i]) begin
         configModeStrap <= modes[i];
         tick(6);
         check({flatGainA, eqIndexA}, 6'h25);
      end
      configModeStrap <= redriver_pkg::MODE_PIN;
      tick(6);
      check(eqIndexA, 4'hB);
      wb(1'h0, 8'h14, 32'h0000_0000);
      check(q, 32'h0000_0000);
      $display("test registers done");
   endtask : t_regs

   task automatic t_detect();
      check({termOnB, termOnA}, 2'h0);
      wait_probe();
      wait_probe();
      check(n, POLL);
      check(probeB, 1'h1);
      presA <= 1'h1;
      presB <= 1'h1;
      wait_term(0, 1'h1);
      wait_term(1, 1'h1);
      wb(1'h0, 8'h0C, 32'h0000_0000);
      check(q[9:4], 6'h3A);
      $display("test detect done");
   endtask : t_detect

   task automatic t_power();
      for (int g = 0; g < 2; g++) begin
         {powerdown_group_b, powerdown_group_a} <= 2'(1 << g);
         tick(PD_HOLD);
         check(g ? pathResetB : pathResetA, 1'h1);
         check(g ? termOnB : termOnA, 1'h0);
         check(g ? termOnA : termOnB, 1'h1);
         {powerdown_group_b, powerdown_group_a} <= 2'h0;
         tick(6);
         check(g ? termOnB : termOnA, 1'h0);
         wait_term(g, 1'h1);
      end
      {powerdown_group_b, powerdown_group_a} <= 2'h3;
      tick(PD_HOLD);
      check({standby, termOnA, termOnB}, 3'h4);
      {powerdown_group_b, powerdown_group_a} <= 2'h0;
      wait_term(0, 1'h1);
      wait_term(1, 1'h1);
      $display("test power-down done");
   endtask : t_power

   task automatic t_cross();
      crosspoint_select_a <= 1'h1;
      tick(5);
      check({crossB, crossA, termOnA}, 3'h2);
      wait_term(0, 1'h1);
      check(termOnB, 1'h1);
      wb(1'h1, 8'h00, 32'h0000_0002);
      tick(3);
      check({termOnB, termOnA}, 2'h1);
      wait_term(1, 1'h1);
      crosspoint_select_b <= 1'h1;
      tick(5);
      check({crossB, termOnB, termOnA}, 3'h5);
      wait_term(1, 1'h1);
      $display("test crosspoint done");
   endtask : t_cross

   task automatic t_buffer();
      rst <= 1'h1;
      detect_mode_strap <= redriver_pkg::DETECT_OFF;
      presA <= 1'h0;
      presB <= 1'h0;
      crosspoint_select_a <= 1'h0;
      tick(4);
      rst <= 1'h0;
      tick(12);
      check({standby, termOnB, termOnA}, 3'h3);
      $display("test buffer mode done");
   endtask : t_buffer

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      {cyc_i, stb_i, we_i, presA, presB} = 5'h00;
      {powerdown_group_a, powerdown_group_b} = 2'h0;
      {crosspoint_select_a, crosspoint_select_b} = 2'h0;
      {sel_i, adr_i, dat_i} = 44'h000_0000_0000;
      eq_upper_strap_group_a = redriver_pkg::LVL_L2;
      eq_lower_strap_group_a = redriver_pkg::LVL_L3;
      eq_upper_strap_group_b = redriver_pkg::LVL_L3;
      eq_lower_strap_group_b = redriver_pkg::LVL_L1;
      flat_gain_strap_group_a = redriver_pkg::LVL_L1;
      flat_gain_strap_group_b = redriver_pkg::LVL_L3;
      configModeStrap = redriver_pkg::MODE_PIN;
      detect_mode_strap = redriver_pkg::LVL_L3;
      tick(12);
      rst <= 1'h0;
      t_straps();
      t_regs();
      t_detect();
      t_power();
      t_cross();
      t_buffer();
      test_done();
   end
endmodule : testbench
